// >>> mcbm_top.sv
`default_nettype none
module mcbm_top #(
    parameter int N_CU = mcbm_pkg::DEF_N_CU,
    parameter int N_CH = mcbm_pkg::DEF_N_CH,
    parameter int N_BANK = mcbm_pkg::DEF_N_BANK
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Compute unit requests
    input wire logic [N_CU-1:0] REQ_VALID,
    input wire logic [N_CU-1:0][mcbm_pkg::ADDR_W-1:0] REQ_ADDR,
    input wire logic [N_CU-1:0][1:0] REQ_OP,
    input wire logic [N_CU-1:0][1:0] REQ_SIZE,
    output logic [N_CU-1:0] REQ_GRANT,
    // Channel issue
    output logic [N_CH-1:0] CH_VALID,
    output logic [N_CH-1:0][$clog2(N_CU)-1:0] CH_CU,
    output logic [N_CH-1:0][$clog2(N_BANK)-1:0] CH_BANK,
    output logic [N_CH-1:0][mcbm_pkg::ELEM_W-1:0] CH_ELEM,
    output logic [N_CH-1:0][mcbm_pkg::ADDR_W-mcbm_pkg::CH_LSB-$clog2(N_CH)-$clog2(N_BANK)-1:0] CH_ROW,
    output logic [N_CH-1:0] CH_FULL,
    output logic [N_CH-1:0][1:0] CH_OP,
    output logic [N_CH-1:0][1:0] CH_SIZE,
    // Acknowledge and holding buffer
    input wire logic ACK_VALID,
    input wire logic [$clog2(N_CU)-1:0] ACK_CU,
    input wire logic [31:0] ACK_DATA,
    input wire logic [N_CU-1:0] WAIT_ACK,
    output logic [N_CU-1:0] SUSPEND,
    input wire logic [$clog2(N_CU)-1:0] HOLD_RD_CU,
    output logic [31:0] HOLD_DATA,
    // Work-group dispatch
    input wire logic START,
    input wire logic [mcbm_pkg::GRP_W-1:0] NUM_X,
    input wire logic [mcbm_pkg::GRP_W-1:0] NUM_Y,
    input wire logic [N_CU-1:0] RETIRE,
    output logic DISP_VALID,
    output logic [$clog2(N_CU)-1:0] DISP_CU,
    output logic [mcbm_pkg::ORD_W-1:0] DISP_ORDER,
    output logic [mcbm_pkg::GRP_W-1:0] DISP_X,
    output logic [mcbm_pkg::GRP_W-1:0] DISP_Y,
    output logic DISP_DONE,
    output logic BUSY,
    // Traffic counters
    input wire logic [mcbm_pkg::BUS_B_W-1:0] BUS_BYTES,
    output logic [mcbm_pkg::CNT_W-1:0] SIMPLE_BYTES,
    output logic [mcbm_pkg::CNT_W-1:0] FULL_BYTES,
    output logic [mcbm_pkg::CNT_W-1:0] TOTAL_BYTES,
    output logic [mcbm_pkg::PCT_W-1:0] SHARE_PCT
);
    localparam int CUW = $clog2(N_CU);
    localparam int CHW = $clog2(N_CH);
    localparam int BKW = $clog2(N_BANK);
    localparam int RW = mcbm_pkg::ADDR_W - mcbm_pkg::CH_LSB - CHW - BKW;
    localparam int BK_LSB = mcbm_pkg::CH_LSB + CHW;
    localparam int SW = mcbm_pkg::CNT_W + 8;

    initial begin
        if (N_CU < 2 || (N_CU & (N_CU - 1)) != 0) $error("N_CU must be a power of two");
        if (N_CH < 2 || (N_CH & (N_CH - 1)) != 0) $error("N_CH must be a power of two");
        if (N_BANK < 2 || (N_BANK & (N_BANK - 1)) != 0) $error("N_BANK must be a power of two");
        if (RW < 1) $error("No row bits left in the address");
    end

    // Channel sits right above the element byte: 256-byte interleave
    function automatic logic [CHW-1:0] ch_of(input logic [mcbm_pkg::ADDR_W-1:0] a);
        return a[mcbm_pkg::CH_LSB +: CHW];
    endfunction : ch_of

    // Bank right above channel, so a linear burst walks channels first
    function automatic logic [BKW-1:0] bank_of(input logic [mcbm_pkg::ADDR_W-1:0] a);
        return a[BK_LSB +: BKW];
    endfunction : bank_of

    function automatic logic [3:0] bytes_of(input logic [1:0] sz);
        case (sz)
            mcbm_pkg::SIZE_BYTE: return 4'h1;
            mcbm_pkg::SIZE_HALF: return 4'h2;
            default: return 4'(mcbm_pkg::WORD_BYTES);
        endcase
    endfunction : bytes_of

    typedef struct packed {
        logic [N_CU-1:0] grant;
        logic [N_CH-1:0] ch_vld;
        logic [N_CH-1:0][CUW-1:0] ch_cu;
        logic [N_CH-1:0][BKW-1:0] ch_bank;
        logic [N_CH-1:0][mcbm_pkg::ELEM_W-1:0] ch_elem;
        logic [N_CH-1:0][RW-1:0] ch_row;
        logic [N_CH-1:0] ch_full;
        logic [N_CH-1:0][1:0] ch_op;
        logic [N_CH-1:0][1:0] ch_size;
        logic [N_CU-1:0][mcbm_pkg::ACK_W-1:0] ack_cnt;
        logic [N_CU-1:0] suspend;
        mcbm_pkg::mcbm_dsp_e dsp;
        logic [mcbm_pkg::GRP_W-1:0] nx;
        logic [mcbm_pkg::GRP_W-1:0] ny;
        logic [mcbm_pkg::GRP_W-1:0] gx;
        logic [mcbm_pkg::GRP_W-1:0] gy;
        logic [N_CU-1:0] busy;
        logic [N_CU-1:0][mcbm_pkg::ORD_W-1:0] cu_ord;
        logic [N_CU-1:0] ret_pend;
        logic [mcbm_pkg::ORD_W-1:0] ret_ord;
        logic disp_vld;
        logic [CUW-1:0] disp_cu;
        logic [mcbm_pkg::ORD_W-1:0] disp_ord;
        logic [mcbm_pkg::GRP_W-1:0] disp_x;
        logic [mcbm_pkg::GRP_W-1:0] disp_y;
        logic done;
        logic [mcbm_pkg::CNT_W-1:0] simple_b;
        logic [mcbm_pkg::CNT_W-1:0] full_b;
        logic [mcbm_pkg::CNT_W-1:0] total_b;
        logic [mcbm_pkg::PCT_W-1:0] share;
    } mcbm_state_s;

    mcbm_state_s st_reg;
    mcbm_state_s st_next;

    always_comb begin
        logic found;
        logic full;
        logic inc;
        logic dec;
        logic [SW-1:0] num;
        logic [SW-1:0] quo;
        st_next = st_reg;
        found = 1'b0;
        full = 1'b0;
        inc = 1'b0;
        dec = 1'b0;
        num = '0;
        quo = '0;
        // One grant per channel; a unit granted last cycle waits a turn,
        // which keeps one low-numbered unit from starving the rest
        st_next.grant = '0;
        st_next.ch_vld = '0;
        for (int c = 0; c < N_CH; c++) begin
            found = 1'b0;
            for (int i = 0; i < N_CU; i++) begin
                // A unit presents one wavefront's access at a time
                if (!found && REQ_VALID[i] && !st_reg.grant[i] && !st_reg.suspend[i]
                        && int'(ch_of(REQ_ADDR[i])) == c) begin
                    found = 1'b1;
                    full = (REQ_OP[i] == 2'(mcbm_pkg::OP_ATOMIC))
                        || (REQ_OP[i] == 2'(mcbm_pkg::OP_NOOP_ACK))
                        || (REQ_SIZE[i] != mcbm_pkg::SIZE_WORD);
                    st_next.grant[i] = 1'b1;
                    st_next.ch_vld[c] = 1'b1;
                    st_next.ch_cu[c] = CUW'(i);
                    st_next.ch_elem[c] = REQ_ADDR[i][mcbm_pkg::ELEM_W-1:0];
                    st_next.ch_bank[c] = bank_of(REQ_ADDR[i]);
                    st_next.ch_row[c] = REQ_ADDR[i][mcbm_pkg::ADDR_W-1:BK_LSB+BKW];
                    st_next.ch_full[c] = full;
                    st_next.ch_op[c] = REQ_OP[i];
                    st_next.ch_size[c] = REQ_SIZE[i];
                    if (full) begin
                        st_next.full_b = st_next.full_b + 32'(bytes_of(REQ_SIZE[i]));
                    end else if (REQ_OP[i] == 2'(mcbm_pkg::OP_STORE)) begin
                        st_next.simple_b = st_next.simple_b + 32'(bytes_of(REQ_SIZE[i]));
                    end
                end
            end
        end
        // Outstanding acks per unit; a wait holds until the count drains
        for (int i = 0; i < N_CU; i++) begin
            inc = st_next.grant[i] && REQ_OP[i] == 2'(mcbm_pkg::OP_NOOP_ACK);
            dec = ACK_VALID && int'(ACK_CU) == i && st_reg.ack_cnt[i] != '0;
            if (inc && !dec) begin
                st_next.ack_cnt[i] = st_reg.ack_cnt[i] + 8'h01;
            end else if (dec && !inc) begin
                st_next.ack_cnt[i] = st_reg.ack_cnt[i] - 8'h01;
            end
            st_next.suspend[i] = WAIT_ACK[i] && st_next.ack_cnt[i] != '0;
        end
        // Path share in percent; the divider is wide but off any hot path
        st_next.total_b = st_reg.total_b + 32'(BUS_BYTES);
        if (st_reg.total_b != '0) begin
            num = (SW'(st_reg.simple_b) + SW'(st_reg.full_b)) * SW'(mcbm_pkg::PCT_FULL);
            quo = num / SW'(st_reg.total_b);
            st_next.share = (quo > SW'(mcbm_pkg::PCT_FULL))
                ? mcbm_pkg::PCT_W'(mcbm_pkg::PCT_FULL) : quo[mcbm_pkg::PCT_W-1:0];
        end else begin
            st_next.share = '0;
        end
        // Work-group dispatch and in-order retirement
        st_next.disp_vld = 1'b0;
        st_next.done = 1'b0;
        st_next.ret_pend = st_reg.ret_pend | (RETIRE & st_reg.busy);
        found = 1'b0;
        for (int i = 0; i < N_CU; i++) begin
            if (!found && st_reg.busy[i] && st_next.ret_pend[i]
                    && st_reg.cu_ord[i] == st_reg.ret_ord) begin
                found = 1'b1;
                st_next.busy[i] = 1'b0;
                st_next.ret_pend[i] = 1'b0;
                st_next.ret_ord = st_reg.ret_ord + 32'h1;
            end
        end
        case (st_reg.dsp)
            mcbm_pkg::DSP_IDLE: begin
                if (START) begin
                    st_next.dsp = mcbm_pkg::DSP_RUN;
                    st_next.nx = NUM_X;
                    st_next.ny = NUM_Y;
                    st_next.gx = '0;
                    st_next.gy = (NUM_X == '0) ? NUM_Y : '0;
                    st_next.ret_ord = '0;
                end
            end
            mcbm_pkg::DSP_RUN: begin
                found = 1'b0;
                if (st_reg.gy < st_reg.ny) begin
                    for (int i = 0; i < N_CU; i++) begin
                        if (!found && !st_reg.busy[i]) begin
                            found = 1'b1;
                            st_next.busy[i] = 1'b1;
                            st_next.cu_ord[i] = 32'(st_reg.gx)
                                + 32'(st_reg.gy) * 32'(st_reg.nx);
                            st_next.disp_vld = 1'b1;
                            st_next.disp_cu = CUW'(i);
                            st_next.disp_ord = st_next.cu_ord[i];
                            st_next.disp_x = st_reg.gx;
                            st_next.disp_y = st_reg.gy;
                            if (st_reg.gx + 16'h1 == st_reg.nx) begin
                                st_next.gx = '0;
                                st_next.gy = st_reg.gy + 16'h1;
                            end else begin
                                st_next.gx = st_reg.gx + 16'h1;
                            end
                        end
                    end
                end else if (st_next.ret_ord == 32'(st_reg.nx) * 32'(st_reg.ny)) begin
                    st_next.dsp = mcbm_pkg::DSP_IDLE;
                    st_next.done = 1'b1;
                end
            end
            default: st_next.dsp = mcbm_pkg::DSP_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Holding buffer for no-op fetch results; second phase reads it back
    mcbm_hold_mem #(
        .DEPTH(N_CU),
        .AW(CUW),
        .W(32)
    ) u_hold (
        .SYS_CLK(SYS_CLK),
        .RST_N(RST_N),
        .we(ACK_VALID),
        .waddr(ACK_CU),
        .wdata(ACK_DATA),
        .raddr(HOLD_RD_CU),
        .rdata(HOLD_DATA)
    );

    assign REQ_GRANT = st_reg.grant;
    assign CH_VALID = st_reg.ch_vld;
    assign CH_CU = st_reg.ch_cu;
    assign CH_BANK = st_reg.ch_bank;
    assign CH_ELEM = st_reg.ch_elem;
    assign CH_ROW = st_reg.ch_row;
    assign CH_FULL = st_reg.ch_full;
    assign CH_OP = st_reg.ch_op;
    assign CH_SIZE = st_reg.ch_size;
    assign SUSPEND = st_reg.suspend;
    assign DISP_VALID = st_reg.disp_vld;
    assign DISP_CU = st_reg.disp_cu;
    assign DISP_ORDER = st_reg.disp_ord;
    assign DISP_X = st_reg.disp_x;
    assign DISP_Y = st_reg.disp_y;
    assign DISP_DONE = st_reg.done;
    assign BUSY = (st_reg.dsp == mcbm_pkg::DSP_RUN);
    assign SIMPLE_BYTES = st_reg.simple_b;
    assign FULL_BYTES = st_reg.full_b;
    assign TOTAL_BYTES = st_reg.total_b;
    assign SHARE_PCT = st_reg.share;

    AST_FIELD_SPLIT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (N_CH == 8 && N_BANK == 16) |->
            ch_of(REQ_ADDR[0]) == REQ_ADDR[0][10:8] && bank_of(REQ_ADDR[0]) == REQ_ADDR[0][14:11])
        else $error("Channel or bank field misplaced");
    AST_CU0_SLOT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        st_reg.grant[0] |-> st_reg.ch_vld[ch_of($past(REQ_ADDR[0]))]
            && st_reg.ch_cu[ch_of($past(REQ_ADDR[0]))] == '0
            && st_reg.ch_elem[ch_of($past(REQ_ADDR[0]))] == $past(REQ_ADDR[0][7:0]))
        else $error("Grant without matching channel slot");
    AST_NO_BACK_TO_BACK: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        st_reg.grant[0] |=> !st_reg.grant[0])
        else $error("Unit granted on two cycles in a row");
    AST_GRANT_COUNT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $countones(st_reg.grant) == $countones(st_reg.ch_vld))
        else $error("Grants and channel issues disagree");
    AST_SIMPLE_PATH: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        st_reg.ch_vld[0] && !st_reg.ch_full[0] |->
            st_reg.ch_size[0] == mcbm_pkg::SIZE_WORD && st_reg.ch_op[0][1] == 1'b0)
        else $error("Simple path carried an unsupported access");
    AST_ACK_COUNT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        st_reg.grant[0] && $past(REQ_OP[0]) == 2'(mcbm_pkg::OP_NOOP_ACK)
            && !$past(ACK_VALID) |-> st_reg.ack_cnt[0] == $past(st_reg.ack_cnt[0]) + 8'h01)
        else $error("No-op fetch did not raise the ack count");
    AST_SUSPEND: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $past(WAIT_ACK[0]) |-> SUSPEND[0] == (st_reg.ack_cnt[0] != '0))
        else $error("Suspend does not track outstanding acks");
    AST_DISP_ORDER: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        st_reg.disp_vld |-> st_reg.disp_ord == 32'(st_reg.disp_x) + 32'(st_reg.disp_y) * 32'(st_reg.nx))
        else $error("Dispatch order is not row-major");
    AST_RETIRE_STEP: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        st_reg.dsp == mcbm_pkg::DSP_RUN && $past(st_reg.dsp) == mcbm_pkg::DSP_RUN |->
            st_reg.ret_ord - $past(st_reg.ret_ord) <= 32'h1)
        else $error("Retire pointer jumped");
    AST_SHARE_RANGE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        st_reg.share <= mcbm_pkg::PCT_W'(mcbm_pkg::PCT_FULL))
        else $error("Share above one hundred percent");
endmodule : mcbm_top
`default_nettype wire

// >>> mcbm_pkg.sv
`default_nettype none
package mcbm_pkg;
    // Address layout
    localparam int ELEM_W = 8;
    localparam int CH_LSB = 8;
    localparam int ADDR_W = 32;
    // Default sizing
    localparam int DEF_N_CU = 8;
    localparam int DEF_N_CH = 8;
    localparam int DEF_N_BANK = 16;
    // Counter and field widths
    localparam int ACK_W = 8;
    localparam int CNT_W = 32;
    localparam int ORD_W = 32;
    localparam int GRP_W = 16;
    localparam int BUS_B_W = 8;
    localparam int PCT_W = 7;
    localparam int PCT_FULL = 100;
    // Access size codes, bytes per element
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam int WORD_BYTES = 4;

    typedef enum logic [1:0] {
        OP_LOAD,
        OP_STORE,
        OP_ATOMIC,
        OP_NOOP_ACK
    } mcbm_op_e;

    typedef enum logic {
        DSP_IDLE,
        DSP_RUN
    } mcbm_dsp_e;
endpackage : mcbm_pkg
`default_nettype wire

// >>> mcbm_hold_mem.sv
`default_nettype none
module mcbm_hold_mem #(
    parameter int DEPTH = 8,
    parameter int AW = 3,
    parameter int W = 32
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [W-1:0] rd;
    } mcbm_mem_s;

    mcbm_mem_s st_reg;
    mcbm_mem_s st_next;

    initial begin
        if (DEPTH < 1 || DEPTH > (1 << AW)) $error("DEPTH does not fit the address width");
    end

    always_comb begin
        st_next = st_reg;
        if (we && int'(waddr) < DEPTH) begin
            st_next.mem[waddr] = wdata;
        end
        st_next.rd = (int'(raddr) < DEPTH) ? st_reg.mem[raddr] : '0;
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata = st_reg.rd;
endmodule : mcbm_hold_mem
`default_nettype wire

// >>> mcbm_cu_model.sv
`default_nettype none
module mcbm_cu_model #(
    parameter int N = 8
) (
    // Clock
    input wire logic clk,
    // Bench control
    input wire logic [N-1:0] stall,
    // Request side
    output logic [N-1:0] req_valid,
    output logic [N-1:0][31:0] req_addr,
    output logic [N-1:0][1:0] req_op,
    output logic [N-1:0][1:0] req_size,
    input wire logic [N-1:0] req_grant
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] q[N][$];
    logic [35:0] w;
    initial begin
        req_valid = '0;
        req_addr = '0;
        req_op = '0;
        req_size = '0;
    end
    // Requests move only after the falling edge and are held until the grant shows
    always @(negedge clk) begin
        for (int i = 0; i < N; i++) begin
            if (req_valid[i] && req_grant[i]) begin
                req_valid[i] <= 1'b0;
                // Released lines must not still look like the last request
                req_addr[i] <= ~req_addr[i];
                req_op[i] <= ~req_op[i];
                req_size[i] <= ~req_size[i];
            end else if (!req_valid[i] && !stall[i] && q[i].size() > 0) begin
                w = q[i].pop_front();
                req_valid[i] <= 1'b1;
                {req_size[i], req_op[i], req_addr[i]} <= w;
            end
        end
    end
endmodule : mcbm_cu_model
`default_nettype wire

// >>> mcbm_top_bench.sv
`default_nettype none
module mcbm_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] rv, gnt, sus, chv, chf, e_v, m_g, m_su, tk, chm;
    logic [7:0][31:0] ra, e_a;
    logic [7:0][1:0] ro, rs, cop, csz, e_o, e_s;
    logic [7:0][2:0] ccu, e_cu;
    logic [7:0][3:0] cbk;
    logic [7:0][7:0] cel;
    logic [7:0][16:0] crw;
    logic [7:0] wack = '0, ret = '0, stl = '0, bus_b = '0;
    logic ack_v = 1'b0, start = 1'b0, rnd_on = 1'b0, dv, dd, busy;
    logic [2:0] ack_cu = '0, hrd = '0, dcu;
    logic [31:0] ack_d = '0, hd, dord, sb, fb, tb, r, lf;
    logic [15:0] nx = '0, ny = '0, dx, dy;
    logic [6:0] pct;
    logic [127:0] seen;
    int cnt[8], m_s, m_f, m_t, bn, err_total = 0, checks = 0, cyc_n = 0;
    int g_nx = 1, d_ord = 0, done_n = 0, puts = 0, gn = 0, n;
    int dq[$];

    mcbm_cu_model cu_model_inst (.clk(clk), .stall(stl), .req_valid(rv), .req_addr(ra),
        .req_op(ro), .req_size(rs), .req_grant(gnt));
    mcbm_top mcbm_top_inst (.SYS_CLK(clk), .RST_N(rst_n), .REQ_VALID(rv), .REQ_ADDR(ra),
        .REQ_OP(ro), .REQ_SIZE(rs), .REQ_GRANT(gnt), .CH_VALID(chv), .CH_CU(ccu),
        .CH_BANK(cbk), .CH_ELEM(cel), .CH_ROW(crw), .CH_FULL(chf), .CH_OP(cop),
        .CH_SIZE(csz), .ACK_VALID(ack_v), .ACK_CU(ack_cu), .ACK_DATA(ack_d),
        .WAIT_ACK(wack), .SUSPEND(sus), .HOLD_RD_CU(hrd), .HOLD_DATA(hd), .START(start),
        .NUM_X(nx), .NUM_Y(ny), .RETIRE(ret), .DISP_VALID(dv), .DISP_CU(dcu),
        .DISP_ORDER(dord), .DISP_X(dx), .DISP_Y(dy), .DISP_DONE(dd), .BUSY(busy),
        .BUS_BYTES(bus_b), .SIMPLE_BYTES(sb), .FULL_BYTES(fb), .TOTAL_BYTES(tb),
        .SHARE_PCT(pct));

    initial begin
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction : nxt

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (e !== g) begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc

    task automatic put(input int u, input logic [31:0] a, input logic [1:0] o,
                       input logic [1:0] s);
        puts++;
        cu_model_inst.q[u].push_back({s, o, a});
    endtask : put

    // Waits for every request to be granted, then lets the counters settle
    task automatic drain;
        int p;
        n = 0;
        while (gn < puts && n < 3000) begin
            cyc(1);
            n++;
        end
        rnd_on = 1'b0;
        cyc(4);
        p = (m_t == 0) ? 0 : (m_s + m_f) * 100 / m_t;
        if (p > 100) p = 100;
        chk("all_granted", puts, gn);
        chk("simple_bytes", m_s, sb);
        chk("full_bytes", m_f, fb);
        chk("total_bytes", m_t, tb);
        chk("share_pct", p, pct);
    endtask : drain

    task automatic wq(input int s);
        n = 0;
        while (dq.size() > s && n < 60) begin
            cyc(1);
            n++;
        end
        chk("dispatch_left", s, dq.size());
    endtask : wq

    task automatic rt(input int u);
        ret = 8'h01 << u;
        cyc(1);
        ret = '0;
        cyc(1);
    endtask : rt

    // Reference arbitration, path, acknowledge and counter model
    always @(posedge clk) begin
        if (!rst_n) begin
            m_g = '0;
            m_su = '0;
            e_v = '0;
            m_s = 0;
            m_f = 0;
            m_t = 0;
            for (int i = 0; i < 8; i++) cnt[i] = 0;
        end else begin
            e_v = '0;
            tk = '0;
            // Count is tested before this cycle's no-op grant adds to it
            if (ack_v && cnt[ack_cu] > 0) cnt[ack_cu]--;
            for (int i = 0; i < 8; i++) begin
                if (rv[i] && !m_g[i] && !m_su[i] && !e_v[ra[i][10:8]]) begin
                    e_v[ra[i][10:8]] = 1'b1;
                    e_cu[ra[i][10:8]] = 3'(i);
                    e_a[ra[i][10:8]] = ra[i];
                    e_o[ra[i][10:8]] = ro[i];
                    e_s[ra[i][10:8]] = rs[i];
                    tk[i] = 1'b1;
                    bn = (rs[i] == 2'h0) ? 1 : ((rs[i] == 2'h1) ? 2 : 4);
                    if (ro[i] >= 2'h2 || rs[i] != 2'h2) m_f += bn;
                    else if (ro[i] == 2'h1) m_s += bn;
                    if (ro[i] == 2'h3) cnt[i]++;
                end
            end
            for (int i = 0; i < 8; i++) m_su[i] = wack[i] && cnt[i] != 0;
            m_g = tk;
            m_t += bus_b;
        end
        cyc_n++;
        if (cyc_n == 20000) begin
            err_total++;
            $display("timeout after %0d cycles", cyc_n);
            complete_run();
        end
    end

    always @(negedge clk) begin
        lf = nxt(lf);
        stl <= rnd_on ? (lf[7:0] & lf[15:8]) : 8'h00;
        bus_b <= rnd_on ? {4'h0, lf[19:16]} : 8'h00;
        if (rst_n) begin
            gn += $countones(gnt);
            chm |= chv;
            chk("grant", m_g, gnt);
            chk("suspend", m_su, sus);
            chk("ch_valid", e_v, chv);
            for (int c = 0; c < 8; c++) begin
                if (e_v[c] === 1'b1) begin
                    seen[{cbk[c], 3'(c)}] = 1'b1;
                    chk("ch_cu", e_cu[c], ccu[c]);
                    chk("ch_elem", e_a[c][7:0], cel[c]);
                    chk("ch_bank", e_a[c][14:11], cbk[c]);
                    chk("ch_row", e_a[c][31:15], crw[c]);
                    chk("ch_full", e_o[c] >= 2'h2 || e_s[c] != 2'h2, chf[c]);
                    chk("ch_op_size", {e_s[c], e_o[c]}, {csz[c], cop[c]});
                end
            end
            if (dv === 1'b1 && dq.size() == 0) begin
                chk("extra_dispatch", 0, 1);
            end else if (dv === 1'b1) begin
                chk("disp_cu", dq.pop_front(), dcu);
                chk("disp_order", d_ord, dord);
                chk("disp_x", d_ord % g_nx, dx);
                chk("disp_y", d_ord / g_nx, dy);
                d_ord++;
            end
            if (dd === 1'b1) done_n++;
        end
    end

    initial begin
        lf = 32'hBA083C95;
        r = 32'hBA083C95;
        seen = '0;
        chm = '0;
        cyc(10);
        rst_n = 1'b1;
        cyc(2);
        chk("reset_total", 0, tb);
        rnd_on = 1'b1;
        for (int k = 0; k < 128; k++) put(k % 8, 32'h00040000 + k * 256, 2'h1, 2'h2);
        drain();
        chk("burst_cover", 1, &seen);
        $display("test burst done");
        chm = '0;
        for (int k = 0; k < 64; k++) put(k % 8, 32'h00012300 + k * 4, 2'h0, 2'h2);
        drain();
        chk("wave_channel", 8'h08, chm);
        $display("test wave done");
        rnd_on = 1'b1;
        for (int k = 0; k < 300; k++) begin
            r = nxt(r);
            put(r[2:0], r, (r[31:30] == 2'h3) ? 2'h2 : r[31:30], r[29:28]);
        end
        drain();
        $display("test random done");
        put(2, 32'h00000A40, 2'h3, 2'h2);
        cyc(3);
        wack[2] = 1'b1;
        cyc(2);
        chk("suspended", 1, sus[2]);
        // The next request must wait out the suspension
        put(2, 32'h00000A80, 2'h0, 2'h2);
        cyc(6);
        chk("held_while_suspended", puts - 1, gn);
        ack_v = 1'b1;
        ack_cu = 3'h2;
        ack_d = r;
        cyc(1);
        ack_v = 1'b0;
        hrd = 3'h2;
        cyc(2);
        chk("hold_data", r, hd);
        wack = '0;
        ack_v = 1'b1;
        ack_cu = 3'h5;
        ack_d = ~r;
        cyc(1);
        ack_v = 1'b0;
        hrd = 3'h5;
        cyc(2);
        chk("hold_zero_count", ~r, hd);
        drain();
        $display("test ack done");
        g_nx = 3;
        for (int k = 0; k < 12; k++) dq.push_back(k % 8);
        nx = 16'h0003;
        ny = 16'h0004;
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        cyc(3);
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        wq(4);
        cyc(4);
        chk("all_units_busy", 4, dq.size());
        chk("busy_run", 1, busy);
        rt(1);
        cyc(3);
        chk("retire_held", 4, dq.size());
        rt(0);
        wq(2);
        rt(2);
        rt(3);
        wq(0);
        for (int u = 7; u >= 0; u--) rt(u);
        n = 0;
        while (done_n < 1 && n < 40) begin
            cyc(1);
            n++;
        end
        cyc(2);
        chk("grid_done", 1, done_n);
        chk("busy_clear", 0, busy);
        nx = 16'h0000;
        ny = 16'h0005;
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        cyc(20);
        chk("empty_grid_done", 2, done_n);
        $display("test dispatch done");
        complete_run();
    end
endmodule : mcbm_top_bench
`default_nettype wire
